// File: dpw_timer.sv
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module dpw_timer #(
    parameter int PRE_W    = 8,
    parameter int PRE_EXP0 = 1,
    parameter int PRE_EXP1 = 2,
    parameter int PRE_EXP2 = 3,
    parameter int PRE_EXP3 = 4
) (
    // Clock, reset, enable
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [dpw_pkg::ADDR_W-1:0]  haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [dpw_pkg::DATA_W-1:0]  hwdata,
    input  wire logic                        hready,
    output logic      [dpw_pkg::DATA_W-1:0]  hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    // General port drive for the shared pins
    input  wire logic                        gpio_a_out,
    input  wire logic                        gpio_a_oe,
    input  wire logic                        gpio_b_out,
    input  wire logic                        gpio_b_oe,
    // Shared pins
    output logic                             port_pin_a_out,
    output logic                             port_pin_a_oe,
    output logic                             port_pin_b_out,
    output logic                             port_pin_b_oe,
    // Interrupt requests
    output logic                             ch_one_irq,
    output logic                             ch_two_irq
);
    import dpw_pkg::*;

    if (PRE_EXP0 < 1 || PRE_EXP1 < 1 || PRE_EXP2 < 1 || PRE_EXP3 < 1 ||
        PRE_EXP0 > PRE_W || PRE_EXP1 > PRE_W || PRE_EXP2 > PRE_W || PRE_EXP3 > PRE_W)
    begin : g_bad_prescale
        $error("dpw_timer: prescaler exponents must lie in 1..PRE_W");
    end

    // Tick when the low e bits of the prescaler are all ones
    function automatic logic pre_tick(input logic [PRE_W-1:0] c, input logic [1:0] sel);
        logic [PRE_W-1:0] m;
        int               e;
        case (sel)
            2'h0:    e = PRE_EXP0;
            2'h1:    e = PRE_EXP1;
            2'h2:    e = PRE_EXP2;
            default: e = PRE_EXP3;
        endcase
        m = PRE_W'((64'h1 << e) - 64'h1);
        return (c & m) == m;
    endfunction : pre_tick

    dpw_bus_state_type      st_ff;
    logic [DEC_W-1:0]       addr_ff;
    logic [DATA_W-1:0]      hrdata_ff;
    logic                   hready_ff;
    logic [1:0]             run_en_ff;
    logic                   chain_ff;
    logic [1:0]             flag_ff;
    logic [1:0]             ie_ff;
    logic [1:0]             pin_sel_ff;
    logic                   comb_ff;
    logic [1:0][CNT_W-1:0]  cmp_ff;
    logic [1:0]             mode_ff;
    logic [1:0]             seven_ff;
    logic [1:0][1:0]        csel_ff;
    logic [PRE_W-1:0]       pre_ff;
    logic [1:0][CNT_W-1:0]  cnt_ff;
    logic [1:0][CNT_W-1:0]  lat_ff;
    logic [1:0]             wave_ff;
    logic                   wave1_q_ff;
    logic [1:0]             irq_ff;
    logic                   pin_a_out_ff;
    logic                   pin_a_oe_ff;
    logic                   pin_b_out_ff;
    logic                   pin_b_oe_ff;

    logic [1:0][CNT_W-1:0]  nxt_cnt;
    logic [1:0][CNT_W-1:0]  nxt_lat;
    logic [1:0]             nxt_wave;
    logic [1:0]             nxt_flag;
    logic [1:0]             nxt_ie;
    logic [1:0]             hit;
    logic [7:0]             rd_run;
    logic [7:0]             rd_pin;
    logic [7:0]             rd_mode;
    dpw_bus_state_type      nxt_st;

    // Bus decode
    wire                    bus_req  = hsel & hready & htrans[1];
    wire                    wr_phase = (st_ff == BUS_WRITE);
    wire                    wr_run   = wr_phase && (addr_ff == OFS_RUN);
    wire                    wr_pin   = wr_phase && (addr_ff == OFS_PIN);
    wire                    wr_cmp1  = wr_phase && (addr_ff == OFS_CMP1);
    wire                    wr_cmp2  = wr_phase && (addr_ff == OFS_CMP2);
    wire                    wr_mode  = wr_phase && (addr_ff == OFS_MODE);
    wire [7:0]              wd       = hwdata[7:0];

    // Channel clocking
    wire                    ch1_rise = wave_ff[0] & ~wave1_q_ff;
    wire [1:0]              pwm      = mode_ff & {2{~comb_ff}};
    wire [1:0]              tick     = {chain_ff ? ch1_rise : pre_tick(pre_ff, csel_ff[1]),
                                        pre_tick(pre_ff, csel_ff[0])};
    wire [1:0]              set_flag = {hit[1] & (comb_ff | ~mode_ff[1]),
                                        hit[0] & ~comb_ff & ~mode_ff[0]};

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            BUS_IDLE, BUS_WRITE: begin
                if (bus_req) begin
                    nxt_st = hwrite ? BUS_WRITE : BUS_READ;
                end else begin
                    nxt_st = BUS_IDLE;
                end
            end
            BUS_READ: nxt_st = BUS_IDLE;
            default:  nxt_st = BUS_IDLE;
        endcase
    end

    // Read views; unused bits and compare registers read as zero
    always_comb begin
        rd_run               = REG_RESET;
        rd_run[RUN1_BIT]     = run_en_ff[0];
        rd_run[RUN2_BIT]     = run_en_ff[1];
        rd_run[CHAIN_BIT]    = chain_ff;
        rd_run[FLG1_BIT]     = flag_ff[0];
        rd_run[FLG2_BIT]     = flag_ff[1];
        rd_run[IE1_BIT]      = ie_ff[0];
        rd_run[IE2_BIT]      = ie_ff[1];
        rd_pin               = REG_RESET;
        rd_pin[PIN2_BIT]     = pin_sel_ff[1];
        rd_pin[PIN1_BIT]     = pin_sel_ff[0];
        rd_pin[COMB_BIT]     = comb_ff;
        rd_mode              = REG_RESET;
        rd_mode[MODE1_BIT]   = mode_ff[0];
        rd_mode[MODE2_BIT]   = mode_ff[1];
        rd_mode[SEVEN1_BIT]  = seven_ff[0];
        rd_mode[SEVEN2_BIT]  = seven_ff[1];
        rd_mode[CS1_LO+:2]   = csel_ff[0];
        rd_mode[CS2_LO+:2]   = csel_ff[1];
    end

    wire [7:0] rd_sel = (addr_ff == OFS_RUN)  ? rd_run  :
                        (addr_ff == OFS_PIN)  ? rd_pin  :
                        (addr_ff == OFS_MODE) ? rd_mode : REG_RESET;

    // Counter, compare latch and wave generation
    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_lat  = lat_ff;
        nxt_wave = wave_ff;
        hit      = 2'b00;
        for (int i = 0; i < 2; i++) begin
            if (!run_en_ff[i]) begin
                nxt_cnt[i] = CNT_ZERO;
                nxt_lat[i] = cmp_ff[i];
                if (!pwm[i]) begin
                    nxt_wave[i] = 1'b0;
                end
            end else if (tick[i]) begin
                if (pwm[i]) begin
                    if (cnt_ff[i] == (seven_ff[i] ? CNT_MAX7 : CNT_MAX8)) begin
                        nxt_cnt[i]  = CNT_ZERO;
                        nxt_lat[i]  = cmp_ff[i];
                        nxt_wave[i] = (cmp_ff[i] != CNT_ZERO);
                    end else begin
                        nxt_cnt[i] = cnt_ff[i] + CNT_ONE;
                        if (nxt_cnt[i] == lat_ff[i]) begin
                            nxt_wave[i] = 1'b0;
                        end
                    end
                end else if (cnt_ff[i] == lat_ff[i]) begin
                    hit[i] = 1'b1;
                    if (comb_ff && i == 0) begin
                        nxt_wave[i] = 1'b1;
                    end else begin
                        nxt_cnt[i]  = CNT_ZERO;
                        nxt_lat[i]  = cmp_ff[i];
                        nxt_wave[i] = ~wave_ff[i];
                    end
                end else begin
                    nxt_cnt[i] = cnt_ff[i] + CNT_ONE;
                end
            end
        end
        if (comb_ff && hit[1]) begin
            nxt_cnt[0]  = CNT_ZERO;
            nxt_lat[0]  = cmp_ff[0];
            nxt_wave[0] = 1'b0;
        end
    end

    // Hardware set wins over a software clear
    assign nxt_flag[0] = set_flag[0] | (flag_ff[0] & ~(wr_run & ~wd[FLG1_BIT]));
    assign nxt_flag[1] = set_flag[1] | (flag_ff[1] & ~(wr_run & ~wd[FLG2_BIT]));
    assign nxt_ie      = wr_run ? {wd[IE2_BIT], wd[IE1_BIT]} : ie_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff     <= BUS_IDLE;
            addr_ff   <= REG_RESET;
            hrdata_ff <= RDATA_ZERO;
            hready_ff <= 1'b1;
        end else if (ce) begin
            st_ff <= nxt_st;
            if (bus_req) begin
                addr_ff <= haddr[DEC_W-1:0];
            end
            if (bus_req && !hwrite) begin
                hready_ff <= 1'b0;
            end else if (st_ff == BUS_READ) begin
                hready_ff <= 1'b1;
                hrdata_ff <= {24'h00_0000, rd_sel};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_en_ff  <= 2'b00;
            chain_ff   <= 1'b0;
            ie_ff      <= 2'b00;
            pin_sel_ff <= 2'b00;
            comb_ff    <= 1'b0;
            cmp_ff     <= '0;
            mode_ff    <= 2'b00;
            seven_ff   <= 2'b00;
            csel_ff    <= '0;
        end else if (ce) begin
            if (wr_run) begin
                run_en_ff <= {wd[RUN2_BIT], wd[RUN1_BIT]};
                chain_ff  <= wd[CHAIN_BIT];
            end
            ie_ff <= nxt_ie;
            if (wr_pin) begin
                pin_sel_ff <= {wd[PIN2_BIT], wd[PIN1_BIT]};
                comb_ff    <= wd[COMB_BIT];
            end
            if (wr_cmp1) begin
                cmp_ff[0] <= wd;
            end
            if (wr_cmp2) begin
                cmp_ff[1] <= wd;
            end
            if (wr_mode) begin
                mode_ff  <= {wd[MODE2_BIT], wd[MODE1_BIT]};
                seven_ff <= {wd[SEVEN2_BIT], wd[SEVEN1_BIT]};
                csel_ff  <= {wd[CS2_LO+:2], wd[CS1_LO+:2]};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff     <= '0;
            cnt_ff     <= '0;
            lat_ff     <= '0;
            wave_ff    <= 2'b00;
            wave1_q_ff <= 1'b0;
            flag_ff    <= 2'b00;
            irq_ff     <= 2'b00;
        end else if (ce) begin
            pre_ff     <= (|run_en_ff) ? pre_ff + PRE_W'(1) : '0;
            cnt_ff     <= nxt_cnt;
            lat_ff     <= nxt_lat;
            wave_ff    <= nxt_wave;
            wave1_q_ff <= wave_ff[0];
            flag_ff    <= nxt_flag;
            irq_ff     <= nxt_flag & nxt_ie;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_a_out_ff <= 1'b0;
            pin_a_oe_ff  <= 1'b0;
            pin_b_out_ff <= 1'b0;
            pin_b_oe_ff  <= 1'b0;
        end else if (ce) begin
            pin_a_out_ff <= pin_sel_ff[0] ? wave_ff[0] : gpio_a_out;
            pin_a_oe_ff  <= pin_sel_ff[0] | gpio_a_oe;
            pin_b_out_ff <= pin_sel_ff[1] ? wave_ff[1] : gpio_b_out;
            pin_b_oe_ff  <= pin_sel_ff[1] | gpio_b_oe;
        end
    end

    assign hrdata         = hrdata_ff;
    assign hreadyout      = hready_ff;
    assign hresp          = HRESP_OKAY;
    assign port_pin_a_out = pin_a_out_ff;
    assign port_pin_a_oe  = pin_a_oe_ff;
    assign port_pin_b_out = pin_b_out_ff;
    assign port_pin_b_oe  = pin_b_oe_ff;
    assign ch_one_irq     = irq_ff[0];
    assign ch_two_irq     = irq_ff[1];

    property p_stop_clear;
        @(posedge clk) disable iff (!rst_n)
        (ce && !run_en_ff[0]) |=> (cnt_ff[0] == CNT_ZERO);
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not zero");

    property p_chain_hold;
        @(posedge clk) disable iff (!rst_n)
        (ce && chain_ff && run_en_ff[1] && !pwm[1] && !ch1_rise && !comb_ff)
            |=> $stable(cnt_ff[1]);
    endproperty
    a_chain_hold: assert property (p_chain_hold) else $error("chained counter moved");

    property p_irq_level;
        @(posedge clk) disable iff (!rst_n)
        (ch_one_irq == (flag_ff[0] && ie_ff[0])) && (ch_two_irq == (flag_ff[1] && ie_ff[1]));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq differs from flag and enable");

    property p_interval_match;
        @(posedge clk) disable iff (!rst_n)
        (ce && run_en_ff[0] && tick[0] && !pwm[0] && !comb_ff && cnt_ff[0] == lat_ff[0])
            |=> (cnt_ff[0] == CNT_ZERO) && flag_ff[0] && (wave_ff[0] != $past(wave_ff[0]));
    endproperty
    a_interval_match: assert property (p_interval_match) else $error("interval match wrong");

    property p_pwm_no_flag;
        @(posedge clk) disable iff (!rst_n)
        (ce && run_en_ff[0] && pwm[0] && !flag_ff[0]) |=> !flag_ff[0];
    endproperty
    a_pwm_no_flag: assert property (p_pwm_no_flag) else $error("flag set in PWM");

    property p_flag_clear;
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_run && !wd[FLG2_BIT] && !set_flag[1]) |=> !flag_ff[1];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by 0");

    property p_pwm_low;
        @(posedge clk) disable iff (!rst_n)
        (ce && run_en_ff[1] && pwm[1] && tick[1] && lat_ff[1] != CNT_ZERO &&
         cnt_ff[1] + CNT_ONE == lat_ff[1]) |=> !wave_ff[1];
    endproperty
    a_pwm_low: assert property (p_pwm_low) else $error("PWM wave not low at match");

    property p_comb_clear;
        @(posedge clk) disable iff (!rst_n)
        (ce && comb_ff && hit[1])
            |=> (cnt_ff == '0) && !wave_ff[0] && flag_ff[1];
    endproperty
    a_comb_clear: assert property (p_comb_clear) else $error("combined clear wrong");

    property p_pin_route;
        @(posedge clk) disable iff (!rst_n)
        (ce && pin_sel_ff[1]) |=> (port_pin_b_oe && port_pin_b_out == $past(wave_ff[1]));
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("pin b not routed");

    property p_read_wait;
        @(posedge clk) disable iff (!rst_n)
        (ce && bus_req && !hwrite) |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

endmodule : dpw_timer

// File: dpw_pkg.sv
// Operation
// - Run-enable 1 starts a channel; 0 stops it and zeroes its counter.
// - Chained clock 0: channel two uses own tick; 1: channel one square wave.
// - Unused control bits read as zero and writes to them do nothing.
// - Channel-one flag sets on compare match in interval operation.
// - Channel-two flag sets on match in interval operation or combined mode.
// - Each interrupt line is high exactly while its flag and enable are both high.
// - Ordinary PWM operation raises no interrupt flags.
// - Writing 0 clears a flag, writing 1 leaves it alone.
// - Channel-two pin select hands pin b to the port or to channel two wave.
// - Channel-one pin select hands pin a to the port or to channel one wave.
// - Combined mode: channel one sets low width, channel two period; modes ignored.
// - Interval match clears the counter and sets the channel flag.
// - Interval compare writes are used only after the current match.
// - PWM output is high until counter equals compare, then low until overflow.
// - PWM compare writes take effect only after the counter overflows.
// - PWM period is 256 ticks at 8-bit, 128 ticks at 7-bit resolution.
// - Interval period is compare plus one ticks, or channel-one periods when chained.
// - Combined mode: channel-one output low for compare plus one ticks.
// - Compare registers are write-only and read back as zero.
// - Combined channel-two match clears both counters, sets flag two, drives wave one low.
// - Interval output toggles and counter clears on the tick after the match.
package dpw_pkg;

    localparam int          DATA_W      = 32;
    localparam int          ADDR_W      = 32;
    localparam int          DEC_W       = 8;
    localparam int          CNT_W       = 8;

    // Register byte offsets
    localparam logic [7:0]  OFS_RUN     = 8'h00;
    localparam logic [7:0]  OFS_PIN     = 8'h04;
    localparam logic [7:0]  OFS_CMP1    = 8'h08;
    localparam logic [7:0]  OFS_CMP2    = 8'h0c;
    localparam logic [7:0]  OFS_MODE    = 8'h10;

    // Run and interrupt control fields
    localparam int          RUN1_BIT    = 7;
    localparam int          RUN2_BIT    = 6;
    localparam int          CHAIN_BIT   = 5;
    localparam int          FLG1_BIT    = 3;
    localparam int          FLG2_BIT    = 2;
    localparam int          IE1_BIT     = 1;
    localparam int          IE2_BIT     = 0;

    // Pin and combine control fields
    localparam int          PIN2_BIT    = 6;
    localparam int          PIN1_BIT    = 5;
    localparam int          COMB_BIT    = 4;

    // Mode and clock select fields
    localparam int          MODE1_BIT   = 7;
    localparam int          MODE2_BIT   = 6;
    localparam int          SEVEN1_BIT  = 5;
    localparam int          SEVEN2_BIT  = 4;
    localparam int          CS1_LO      = 2;
    localparam int          CS2_LO      = 0;

    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [7:0]  CNT_ZERO    = 8'h00;
    localparam logic [7:0]  CNT_ONE     = 8'h01;
    localparam logic [7:0]  CNT_MAX8    = 8'hff;
    localparam logic [7:0]  CNT_MAX7    = 8'h7f;
    localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;
    localparam logic        HRESP_OKAY  = 1'b0;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ  = 3'b100
    } dpw_bus_state_type;

endpackage : dpw_pkg

// File: tb_dual_pwm_interval_timer_ctrl.sv
`timescale 1ns/1ps
module tb_dual_pwm_interval_timer_ctrl;
    import dpw_pkg::*;

    logic               clk;
    logic               rst_n;
    logic               ce;
    logic               hsel;
    logic [ADDR_W-1:0]  haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic [DATA_W-1:0]  hwdata;
    logic [DATA_W-1:0]  hrdata;
    logic               hreadyout;
    logic               hresp;
    logic               gpio_a_out;
    logic               gpio_a_oe;
    logic               gpio_b_out;
    logic               gpio_b_oe;
    logic               port_pin_a_out;
    logic               port_pin_a_oe;
    logic               port_pin_b_out;
    logic               port_pin_b_oe;
    logic               ch_one_irq;
    logic               ch_two_irq;
    logic [31:0]        exp_q[$];
    logic               rd_dph = 1'b0;
    int                 num_errors;
    int                 check_count;
    int                 seed;
    int                 n1;
    int                 n2;
    int                 c1;
    int                 c2;

    // Expected widths assume ticks every 2 clocks on select 0 and every 4 on select 1
    dpw_timer #(.PRE_EXP0(1), .PRE_EXP1(2)) dpw_timer_inst (
        .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .gpio_a_out(gpio_a_out), .gpio_a_oe(gpio_a_oe), .gpio_b_out(gpio_b_out),
        .gpio_b_oe(gpio_b_oe), .port_pin_a_out(port_pin_a_out),
        .port_pin_a_oe(port_pin_a_oe), .port_pin_b_out(port_pin_b_out),
        .port_pin_b_oe(port_pin_b_oe), .ch_one_irq(ch_one_irq), .ch_two_irq(ch_two_irq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // Read data is judged here against the oldest noted expectation
    always @(posedge clk) begin
        if (rd_dph && hreadyout) begin
            if (exp_q.size() == 0) begin
                chk("unexpected read", 32'h0, 32'h1);
            end else begin
                chk("hrdata", exp_q.pop_front(), hrdata);
                chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
            end
        end
        // A read data phase lasts through its wait state
        if (hreadyout) begin
            rd_dph = htrans[1] && !hwrite && hsel;
        end
    end

    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {8'(seed), 16'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(a, 1'b0, 8'h00);
    endtask : rd

    // Counts clocks until the chosen pin reaches lvl from the other level
    task automatic wait_edge(input int p, input logic lvl, output int n);
        logic prev;
        logic cur;
        n = 0;
        cur = p ? port_pin_b_out : port_pin_a_out;
        do begin
            prev = cur;
            @(posedge clk);
            cur = p ? port_pin_b_out : port_pin_a_out;
            n++;
        end while (!(cur === lvl && prev !== lvl));
    endtask : wait_edge

    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        summarize();
    end

    initial begin
        seed = 32'hbae13b6d;
        {rst_n, ce, hsel, hwrite} = 4'b0110;
        {gpio_a_out, gpio_a_oe, gpio_b_out, gpio_b_oe} = 4'h0;
        haddr = '0;
        htrans = 2'b00;
        hsize = 3'b010;
        hwdata = '0;
        num_errors = 0;
        check_count = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {gpio_a_out, gpio_a_oe, gpio_b_out, gpio_b_oe} <= 4'($random(seed));
            repeat (3) @(posedge clk);
            chk("pin a", {30'h0, gpio_a_out, gpio_a_oe}, {30'h0, port_pin_a_out, port_pin_a_oe});
            chk("pin b", {30'h0, gpio_b_out, gpio_b_oe}, {30'h0, port_pin_b_out, port_pin_b_oe});
        end
        exp_q.delete();
        for (int a = 0; a < 6; a++) rd(8'(a * 4), REG_RESET);
        wr(OFS_RUN, 8'h10);
        rd(OFS_RUN, 8'h00);
        wr(OFS_PIN, 8'h8f);
        rd(OFS_PIN, 8'h00);
        // Interval on channel one, channel two chained to its square wave
        c1 = 1 + ($random(seed) & 3);
        c2 = 1 + ($random(seed) & 3);
        wr(OFS_CMP1, 8'(c1));
        wr(OFS_CMP2, 8'(c2));
        wr(OFS_PIN, 8'h60);
        wr(OFS_RUN, 8'he0);
        wait_edge(0, 1'b1, n1);
        wait_edge(0, 1'b1, n1);
        chk("ch one interval period", 32'(4 * (c1 + 1)), 32'(n1));
        wait_edge(1, 1'b1, n2);
        wait_edge(1, 1'b1, n2);
        chk("ch two chained period", 32'(8 * (c1 + 1) * (c2 + 1)), 32'(n2));
        rd(OFS_RUN, 8'hec);
        wr(OFS_RUN, 8'h0f);
        repeat (2) @(posedge clk);
        chk("irq pair", 32'h3, {30'h0, ch_one_irq, ch_two_irq});
        rd(OFS_RUN, 8'h0f);
        wr(OFS_RUN, 8'h07);
        repeat (2) @(posedge clk);
        chk("irq pair", 32'h1, {30'h0, ch_one_irq, ch_two_irq});
        rd(OFS_RUN, 8'h07);
        wr(OFS_RUN, 8'h00);
        // Both channels PWM at 8-bit then 7-bit resolution, channel one on select 1
        for (int r = 0; r < 2; r++) begin
            c1 = 1 + ($random(seed) & 8'h3f);
            c2 = 1 + ($random(seed) & 8'h3f);
            wr(OFS_MODE, r ? 8'hf4 : 8'hc4);
            wr(OFS_CMP1, 8'(c1));
            wr(OFS_CMP2, 8'(c2));
            wr(OFS_PIN, 8'h60);
            wr(OFS_RUN, 8'hc0);
            wait_edge(1, 1'b1, n1);
            wait_edge(1, 1'b0, n1);
            wait_edge(1, 1'b1, n2);
            chk("pwm high width", 32'(2 * c2), 32'(n1));
            chk("pwm period", 32'(r ? 256 : 512), 32'(n1 + n2));
            wait_edge(0, 1'b1, n1);
            wait_edge(0, 1'b0, n1);
            wait_edge(0, 1'b1, n2);
            chk("ch one pwm high width", 32'(4 * c1), 32'(n1));
            chk("ch one pwm period", 32'(r ? 512 : 1024), 32'(n1 + n2));
            rd(OFS_RUN, 8'hc0);
            wr(OFS_RUN, 8'h00);
        end
        // Combined mode: low width from channel one, period from channel two
        c1 = 1 + ($random(seed) & 3);
        c2 = c1 + 2 + ($random(seed) & 3);
        wr(OFS_MODE, 8'hc0);
        wr(OFS_CMP1, 8'(c1));
        wr(OFS_CMP2, 8'(c2));
        wr(OFS_PIN, 8'h30);
        wr(OFS_RUN, 8'hc0);
        wait_edge(0, 1'b0, n1);
        wait_edge(0, 1'b1, n1);
        wait_edge(0, 1'b0, n2);
        chk("combined low width", 32'(2 * (c1 + 1)), 32'(n1));
        chk("combined period", 32'(2 * (c2 + 1)), 32'(n1 + n2));
        rd(OFS_RUN, 8'hc4);
        wr(OFS_RUN, 8'h00);
        wr(OFS_PIN, 8'h00);
        repeat (4) @(posedge clk);
        chk("read queue empty", 32'h0, 32'(exp_q.size()));
        summarize();
    end
endmodule : tb_dual_pwm_interval_timer_ctrl
